/* logic/dls_consts.vh */
// Offsets, field positions and timing counts of the loop status snapshot bank
`ifndef DLS_CONSTS_VH
`define DLS_CONSTS_VH
`define DLS_OFF_UPDATE      8'h25
`define DLS_OFF_GAIN_B0     8'h27
`define DLS_OFF_GAIN_B1     8'h28
`define DLS_OFF_GAIN_NIB    8'h29
`define DLS_OFF_COCHAN      8'h2A
`define DLS_OFF_TIME_B0     8'h2B
`define DLS_OFF_TIME_B1     8'h2C
`define DLS_OFF_TIME_B2     8'h2D
`define DLS_OFF_TIME_B3     8'h2E
`define DLS_OFF_TIME_B4     8'h2F
`define DLS_OFF_TIME_NIB    8'h30
`define DLS_UPDATE_BIT      0
`define DLS_GAIN_W          20
`define DLS_TIME_W          44
`define DLS_SNAP_LAT_NS     100
`define DLS_CLK_PERIOD_NS   50
`define DLS_SNAP_CYCLES     2'h2
`define DLS_RST_BYTE        8'h00
`define DLS_RST_NIB         4'h0
`define DLS_RST_CNT         2'h0
`endif

/* logic/dls_status_bank.v */
// Loop accumulator snapshot status bank with update handshake
// Operation
// - Gain accumulator bits 7:0 at 27h
// - Gain upper bits held at 28h, 29h
// - Gain bits 15:8 fill all of 28h
// - 29h holds gain 19:16, top nibble zero
// - Snapshot refreshes only on update write
// - 2Ah bit0 shows cochannel detect, rest zero
// - Timing accumulator from 2Bh through 30h
// - Timing bits 15:8..39:32 at 2Ch..2Fh
// - Update bit clears when snapshot completes
`timescale 1ns/10ps
`include "dls_consts.vh"
module dls_status_bank (
  clk,
  sys_rst,
  reg_addr,
  reg_wr,
  reg_wdata,
  reg_rd,
  reg_rdata,
  gain_acc,
  timing_acc,
  cochannel_detected
);
  input  wire         clk;
  input  wire         sys_rst;
  input  wire [7:0]   reg_addr;
  input  wire         reg_wr;
  input  wire [7:0]   reg_wdata;
  input  wire         reg_rd;
  output reg  [7:0]   reg_rdata;
  input  wire [19:0]  gain_acc;
  input  wire [43:0]  timing_acc;
  input  wire         cochannel_detected;

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  reg         state_r;
  reg         state_nxt;
  reg  [1:0]  wait_cnt_r;
  reg  [1:0]  wait_cnt_nxt;
  reg         snap_load;
  reg  [7:0]  gain_b0_r;
  reg  [7:0]  gain_b1_r;
  reg  [3:0]  gain_nib_r;
  reg  [7:0]  time_b0_r;
  reg  [7:0]  time_b1_r;
  reg  [7:0]  time_b2_r;
  reg  [7:0]  time_b3_r;
  reg  [7:0]  time_b4_r;
  reg  [3:0]  time_nib_r;
  reg  [7:0]  gain_rd;
  reg  [7:0]  time_rd;
  reg  [7:0]  ctrl_rd;
  reg  [7:0]  rd_nxt;
  wire        upd_req;
  wire        update_bit;

  function dls_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      dls_hit = (addr == offset);
    end
  endfunction

  function dls_in_range;
    input [7:0] addr;
    input [7:0] first;
    input [7:0] last;
    begin
      dls_in_range = (addr >= first) && (addr <= last);
    end
  endfunction

  // Reserved bits above a nibble field always read as zero
  function [7:0] dls_pad_nib;
    input [3:0] nib;
    begin
      dls_pad_nib = {4'h0, nib};
    end
  endfunction

  function [7:0] dls_pad_flag;
    input flag;
    begin
      dls_pad_flag = {7'h00, flag};
    end
  endfunction

  // Only a one in the update bit of 25h starts a refresh
  assign upd_req = reg_wr && dls_hit(reg_addr, `DLS_OFF_UPDATE) && reg_wdata[`DLS_UPDATE_BIT];

  assign update_bit = (state_r == ST_BUSY);

  // A request while busy is dropped so a poll never sees a restarted window
  always @* begin
    state_nxt = state_r;
    wait_cnt_nxt = wait_cnt_r;
    snap_load = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (upd_req) begin
          state_nxt = ST_BUSY;
          wait_cnt_nxt = `DLS_SNAP_CYCLES;
          snap_load = 1'b1;
        end
      end
      ST_BUSY: begin
        wait_cnt_nxt = wait_cnt_r - 2'h1;
        if (wait_cnt_r == 2'h1) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        wait_cnt_nxt = `DLS_RST_CNT;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      wait_cnt_r <= `DLS_RST_CNT;
    end else begin
      state_r <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
    end
  end

  // Every byte loads on one edge so a multi-byte value never tears
  always @(posedge clk) begin
    if (sys_rst) begin
      gain_b0_r <= `DLS_RST_BYTE;
      gain_b1_r <= `DLS_RST_BYTE;
      gain_nib_r <= `DLS_RST_NIB;
    end else if (snap_load) begin
      gain_b0_r <= gain_acc[7:0];
      gain_b1_r <= gain_acc[15:8];
      gain_nib_r <= gain_acc[19:16];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      time_b0_r <= `DLS_RST_BYTE;
      time_b1_r <= `DLS_RST_BYTE;
      time_b2_r <= `DLS_RST_BYTE;
      time_b3_r <= `DLS_RST_BYTE;
      time_b4_r <= `DLS_RST_BYTE;
      time_nib_r <= `DLS_RST_NIB;
    end else if (snap_load) begin
      time_b0_r <= timing_acc[7:0];
      time_b1_r <= timing_acc[15:8];
      time_b2_r <= timing_acc[23:16];
      time_b3_r <= timing_acc[31:24];
      time_b4_r <= timing_acc[39:32];
      time_nib_r <= timing_acc[43:40];
    end
  end

  // Status offsets have no write path, so host writes there fall away
  always @* begin
    case (reg_addr)
      `DLS_OFF_GAIN_B0:  gain_rd = gain_b0_r;
      `DLS_OFF_GAIN_B1:  gain_rd = gain_b1_r;
      `DLS_OFF_GAIN_NIB: gain_rd = dls_pad_nib(gain_nib_r);
      default:           gain_rd = `DLS_RST_BYTE;
    endcase
  end

  always @* begin
    case (reg_addr)
      `DLS_OFF_TIME_B0:  time_rd = time_b0_r;
      `DLS_OFF_TIME_B1:  time_rd = time_b1_r;
      `DLS_OFF_TIME_B2:  time_rd = time_b2_r;
      `DLS_OFF_TIME_B3:  time_rd = time_b3_r;
      `DLS_OFF_TIME_B4:  time_rd = time_b4_r;
      `DLS_OFF_TIME_NIB: time_rd = dls_pad_nib(time_nib_r);
      default:           time_rd = `DLS_RST_BYTE;
    endcase
  end

  // The detector flag is read live; it is not part of the snapshot
  always @* begin
    case (reg_addr)
      `DLS_OFF_UPDATE:   ctrl_rd = dls_pad_flag(update_bit);
      `DLS_OFF_COCHAN:   ctrl_rd = dls_pad_flag(cochannel_detected);
      default:           ctrl_rd = `DLS_RST_BYTE;
    endcase
  end

  // Group select keeps the final mux narrow; unmapped offsets read zero
  always @* begin
    if (dls_in_range(reg_addr, `DLS_OFF_GAIN_B0, `DLS_OFF_GAIN_NIB)) begin
      rd_nxt = gain_rd;
    end else if (dls_in_range(reg_addr, `DLS_OFF_TIME_B0, `DLS_OFF_TIME_NIB)) begin
      rd_nxt = time_rd;
    end else begin
      rd_nxt = ctrl_rd;
    end
  end

  // Read data is registered and stands until the next read strobe
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= `DLS_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end
  end

endmodule // dls_status_bank

/* bench/dls_props.sv */
// Concurrent checks on the ports of the loop status bank
`timescale 1ns/10ps
module dls_props (
  clk,
  sys_rst,
  reg_addr,
  reg_wr,
  reg_wdata,
  reg_rd,
  reg_rdata
);
  input wire       clk;
  input wire       sys_rst;
  input wire [7:0] reg_addr;
  input wire       reg_wr;
  input wire [7:0] reg_wdata;
  input wire       reg_rd;
  input wire [7:0] reg_rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_upd_wr;
    reg_wr && (reg_addr == 8'h25) && reg_wdata[0];
  endsequence

  sequence s_poll;
    reg_rd && (reg_addr == 8'h25);
  endsequence

  AST_UPD_BUSY: assert property (s_upd_wr ##2 s_poll |=> reg_rdata == 8'h01)
    else $error("update bit not set during snapshot");
  AST_UPD_DONE: assert property (s_upd_wr ##4 s_poll |=> reg_rdata == 8'h00)
    else $error("update bit not cleared after snapshot");
  AST_UPD_RSV: assert property (s_poll |=> reg_rdata[7:1] == 7'h00)
    else $error("reserved update bits not zero");
  AST_NIB_GAIN: assert property (reg_rd && (reg_addr == 8'h29) |=> reg_rdata[7:4] == 4'h0)
    else $error("gain nibble reserved bits not zero");
  AST_COCHAN: assert property (reg_rd && (reg_addr == 8'h2A) |=> reg_rdata[7:1] == 7'h00)
    else $error("detect reserved bits not zero");
  AST_NIB_TIME: assert property (reg_rd && (reg_addr == 8'h30) |=> reg_rdata[7:4] == 4'h0)
    else $error("timing nibble reserved bits not zero");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_RST_RDATA: assert property (disable iff (1'b0) sys_rst |=> reg_rdata == 8'h00)
    else $error("read data not cleared by reset");
endmodule // dls_props

/* bench/tb_dls_status_bank.sv */
// Directed register bench for the loop status snapshot bank
`timescale 1ns/10ps
module tb_dls_status_bank;
  localparam integer CYCLE_LIMIT = 2000;

  reg         clk;
  reg         sys_rst;
  reg  [7:0]  reg_addr;
  reg         reg_wr;
  reg  [7:0]  reg_wdata;
  reg         reg_rd;
  reg  [19:0] gain_acc;
  reg  [43:0] timing_acc;
  reg         cochannel_detected;
  wire [7:0]  reg_rdata;
  integer     fails = 0;
  integer     check_count = 0;
  integer     cycle_cnt = 0;

  dls_status_bank uut (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .reg_addr           (reg_addr),
    .reg_wr             (reg_wr),
    .reg_wdata          (reg_wdata),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .gain_acc           (gain_acc),
    .timing_acc         (timing_acc),
    .cochannel_detected (cochannel_detected)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A hang runs into this ceiling and still reaches the verdict
  always @(posedge clk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == CYCLE_LIMIT) begin
      fails = fails + 1;
      $display("Error at %0t: cycle limit %h reached at %h", $time, CYCLE_LIMIT, cycle_cnt);
      conclude;
    end
  end

  task wr_reg;
    input [7:0] addr;
    input [7:0] data;
    begin
      @(posedge clk);
      #5;
      reg_addr = addr;
      reg_wdata = data;
      reg_wr = 1'b1;
      @(posedge clk);
      #5;
      reg_wr = 1'b0;
    end
  endtask

  task rd_raw;
    input  [7:0] addr;
    output [7:0] data;
    begin
      @(posedge clk);
      #5;
      reg_addr = addr;
      reg_rd = 1'b1;
      @(posedge clk);
      #5;
      reg_rd = 1'b0;
      data = reg_rdata;
    end
  endtask

  task rd_chk;
    input [7:0] addr;
    input [7:0] exp_val;
    reg   [7:0] got;
    begin
      rd_raw(addr, got);
      check_count = check_count + 1;
      if (got !== exp_val) begin
        fails = fails + 1;
        $display("Error at %0t: offset %h expected %h got %h", $time, addr, exp_val, got);
      end
    end
  endtask

  // Polls stop after a few reads so a stuck update bit cannot hang the run
  task poll_update;
    integer   tries;
    reg [7:0] got;
    begin
      tries = 0;
      got = 8'h01;
      while (got !== 8'h00 && tries < 8) begin
        rd_raw(8'h25, got);
        tries = tries + 1;
      end
      check_count = check_count + 1;
      if (got !== 8'h00) begin
        fails = fails + 1;
        $display("Error at %0t: update bit expected %h got %h", $time, 8'h00, got);
      end
    end
  endtask

  task conclude;
    begin
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    gain_acc = 20'hA5C3E;
    timing_acc = 44'hB961F2E4D7C;
    cochannel_detected = 1'b0;
    repeat (6) @(posedge clk);
    #5;
    sys_rst = 1'b0;
    rd_chk(8'h25, 8'h00);
    rd_chk(8'h27, 8'h00);
    $display("Test reset values done");
    wr_reg(8'h25, 8'h01);
    rd_chk(8'h25, 8'h01);
    poll_update;
    gain_acc = 20'h1B2C4;
    timing_acc = 44'h5A69788796A;
    rd_chk(8'h27, 8'h3E);
    rd_chk(8'h28, 8'h5C);
    rd_chk(8'h29, 8'h0A);
    rd_chk(8'h2A, 8'h00);
    rd_chk(8'h2B, 8'h7C);
    rd_chk(8'h2C, 8'h4D);
    rd_chk(8'h2D, 8'h2E);
    rd_chk(8'h2E, 8'h1F);
    rd_chk(8'h2F, 8'h96);
    rd_chk(8'h30, 8'h0B);
    rd_chk(8'h31, 8'h00);
    $display("Test first snapshot done");
    wr_reg(8'h27, 8'hFF);
    wr_reg(8'h2F, 8'hFF);
    wr_reg(8'h25, 8'h00);
    rd_chk(8'h25, 8'h00);
    rd_chk(8'h27, 8'h3E);
    rd_chk(8'h2F, 8'h96);
    cochannel_detected = 1'b1;
    rd_chk(8'h2A, 8'h01);
    $display("Test ignored writes done");
    wr_reg(8'h25, 8'h01);
    gain_acc = 20'h00000;
    timing_acc = 44'h00000000000;
    poll_update;
    rd_chk(8'h27, 8'hC4);
    rd_chk(8'h28, 8'hB2);
    rd_chk(8'h29, 8'h01);
    rd_chk(8'h2B, 8'h6A);
    rd_chk(8'h2C, 8'h79);
    rd_chk(8'h2D, 8'h88);
    rd_chk(8'h2E, 8'h97);
    rd_chk(8'h2F, 8'hA6);
    rd_chk(8'h30, 8'h05);
    $display("Test coherent snapshot done");
    @(posedge clk);
    #5;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #5;
    sys_rst = 1'b0;
    rd_chk(8'h27, 8'h00);
    rd_chk(8'h2B, 8'h00);
    rd_chk(8'h25, 8'h00);
    $display("Test mid-run reset done");
    conclude;
  end
endmodule // tb_dls_status_bank

bind dls_status_bank dls_props chk (
  .clk       (clk),
  .sys_rst   (sys_rst),
  .reg_addr  (reg_addr),
  .reg_wr    (reg_wr),
  .reg_wdata (reg_wdata),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata)
);
